// ### simon_defs.svh
// constants of the supply integrity monitor
`ifndef SIMON_DEFS_SVH
`define SIMON_DEFS_SVH
`define SIMON_OFS_CSR 8'h3A
`define SIMON_OFS_THR 8'h3E
`define SIMON_OFS_CTL 8'h40
`define SIMON_BIT_IE 0
`define SIMON_BIT_WARN 1
`define SIMON_BIT_BOR 2
`define SIMON_THR_RESET 2'h3
`define SIMON_TRIM_RESET 2'h3
`define SIMON_THR_OFF 2'h3
`define SIMON_CLK_HZ 40000000
`define SIMON_WAKE_NS 33000
`define SIMON_WAKE_CYC ((`SIMON_WAKE_NS * (`SIMON_CLK_HZ / 1000000)) / 1000)
`define SIMON_EXT_MIN_HZ 10000000
`endif

// ### simon_pkg.sv
// types of the supply integrity monitor
package simon_pkg;
	typedef enum logic [1:0] {
		SIMON_RUN,
		SIMON_WAIT,
		SIMON_HALT
	} simon_mode_t;
	typedef struct packed {
		logic brownout;
		logic external;
		logic watchdog;
		logic illegal_op;
	} simon_rst_src_t;
endpackage

// ### simon_supply_model.sv
// comparator and cpu service-entry model facing the supply monitor
`timescale 1ns/1ps
module simon_supply_model (
	input wire logic i_clk_sys,
	input wire logic i_warn_below,
	input wire logic i_bo_below,
	input wire logic i_service_en,
	input wire logic i_warning_irq,
	output logic o_warn_cmp,
	output logic o_brownout_cmp,
	output logic o_irq_ack
);
	logic warn_q = 1'b0;
	logic bo_q = 1'b0;
	logic ack_q = 1'b0;
	logic [1:0] wait_q = 2'h0;
	assign o_warn_cmp = warn_q;
	assign o_brownout_cmp = bo_q;
	assign o_irq_ack = ack_q;
	// analog levels, 1 means supply below the level
	always_ff @(posedge i_clk_sys) begin
		warn_q <= i_warn_below;
		bo_q <= i_bo_below;
	end
	// cpu enters the service routine a few cycles after the request
	always_ff @(posedge i_clk_sys) begin
		ack_q <= 1'b0;
		if (!i_service_en || !i_warning_irq || ack_q) begin
			wait_q <= 2'h0;
		end else if (wait_q == 2'h3) begin
			ack_q <= 1'b1;
		end else begin
			wait_q <= wait_q + 2'h1;
		end
	end
endmodule

// ### simon_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module simon_sync3 #(
	parameter int W = 1
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_sync <= '0;
		end else begin
			for (int k = 0; k < W; k++) begin
				if (s2_q[k] == s3_q[k]) begin
					o_sync[k] <= s3_q[k];
				end
			end
		end
	end
endmodule

// ### simon_top.sv
// supply integrity monitor: flags, thresholds and wishbone registers
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "simon_defs.svh"

// Summary of operation
// - warning flag reads live comparator, read only
// - threshold field selects low, medium, high, off
// - every reset forces threshold field to 11; here only i_reset loads it, the other reset sources leave it
// - interrupt needs enable set and mask clear
// - interrupt on falling and rising threshold crossings
// - pending interrupt cleared on service entry
// - brownout flag set by brownout, cleared on read
// - brownout flag survives external and watchdog resets
// - brownout after watchdog clears watchdog flag
// - below brownout threshold hold reset, pin low
// - wait mode unchanged, warning irq wakes
// - halt freezes register, no warning wake
// - flag undefined when brownout detector absent
// - short dip may reset without setting flag
// - external clock: halt never sets, run needs speed
// - trim bits 6:5, prescaler bits 6:5
// - illegal opcode or prebyte causes a reset
// - option selects brownout level and presence
module simon_top
	import simon_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_por_n,
	input wire logic [7:0] wb_adr_i,
	input wire logic [7:0] wb_dat_i,
	output logic [7:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic i_warn_cmp,
	input wire logic i_brownout_cmp,
	input wire logic i_reset_pin_n,
	input wire logic [1:0] i_opt_brownout_level,
	input wire logic i_opt_brownout_enable,
	input wire logic i_clk_external,
	input wire logic i_ext_clk_fast,
	input wire logic i_internal_clk,
	input wire logic i_wdg_reset,
	input wire logic i_illegal_op,
	input wire logic i_cpu_imask,
	input wire logic i_irq_ack,
	input wire simon_mode_t i_mode,
	output logic o_warning_irq,
	output logic o_wake_wait,
	output logic o_chip_reset,
	output logic o_reset_pin_out,
	output logic o_reset_pin_oe,
	output logic [1:0] o_warning_threshold_field,
	output logic [1:0] o_osc_trim_low_bits,
	output logic [1:0] o_osc_prescaler_select,
	output logic [1:0] o_brownout_level,
	output logic o_brownout_detector_on,
	output logic o_watchdog_reset_flag_clr
);
	localparam int WAKE_CYC = `SIMON_WAKE_CYC;
	localparam logic [7:0] OFS_CSR = `SIMON_OFS_CSR;
	localparam logic [7:0] OFS_THR = `SIMON_OFS_THR;

	logic [2:0] cmp_s;
	logic warn_s;
	logic bo_s;
	logic rpin_s;
	simon_sync3 #(.W(3)) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_async({i_warn_cmp, i_brownout_cmp, ~i_reset_pin_n}),
		.o_sync(cmp_s)
	);
	assign warn_s = cmp_s[2];
	assign bo_s = cmp_s[1];
	assign rpin_s = cmp_s[0];

	logic [1:0] thr_q;
	logic [1:0] trim_q;
	logic [1:0] presc_q;
	logic ie_q;
	logic bor_q;
	logic warn_prev_q;
	logic pend_q;
	logic ack_q;
	logic [15:0] dip_q;
	logic bo_prev_q;
	logic halt_seen_q;
	logic warn_live;
	logic wr;
	logic rd;
	logic hit;
	logic frozen;
	logic warn_edge;
	logic bo_capture;
	simon_rst_src_t rst_src;

	// brownout detector from option: level and presence
	assign o_brownout_level = i_opt_brownout_level;
	assign o_brownout_detector_on = i_opt_brownout_enable;

	// reset sources; brownout holds a static reset with the pin pulled low
	assign rst_src = '{
		brownout: i_opt_brownout_enable & bo_s,
		external: rpin_s,
		watchdog: i_wdg_reset,
		illegal_op: i_illegal_op
	};
	always_comb begin
		o_chip_reset = i_reset | rst_src.external | rst_src.watchdog;
		o_chip_reset = o_chip_reset | rst_src.illegal_op;
		if (rst_src.brownout) begin
			o_chip_reset = 1'b1;
		end
	end
	assign o_reset_pin_out = 1'b0;
	assign o_reset_pin_oe = rst_src.brownout;

	property p_static;
		@(posedge i_clk_sys) i_opt_brownout_enable && bo_s |-> o_chip_reset && o_reset_pin_oe;
	endproperty
	a_static: assert property (p_static)
		else $error("no static reset");

	property p_pin_low;
		@(posedge i_clk_sys) o_reset_pin_oe |-> !o_reset_pin_out;
	endproperty
	a_pin_low: assert property (p_pin_low)
		else $error("reset pin driven high");

	property p_illegal;
		@(posedge i_clk_sys) i_illegal_op |-> o_chip_reset;
	endproperty
	a_illegal: assert property (p_illegal)
		else $error("illegal op no reset");

	// warning off when threshold field is 11
	assign warn_live = (thr_q != `SIMON_THR_OFF) & warn_s;
	assign frozen = (i_mode == SIMON_HALT);

	function automatic logic is_mapped(input logic [7:0] adr);
		return (adr == OFS_CSR) || (adr == OFS_THR);
	endfunction

	assign hit = wb_cyc_i & wb_stb_i & ~ack_q;
	// write lands on the acknowledged edge while the master still holds
	assign wr = wb_ack_o & wb_we_i & wb_sel_i & ~frozen;
	assign rd = hit & ~wb_we_i;

	// bus answers one cycle after the strobe; unmapped gives err
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= hit;
		end
	end
	assign wb_ack_o = ack_q & wb_cyc_i & wb_stb_i & is_mapped(wb_adr_i);
	assign wb_err_o = ack_q & wb_cyc_i & wb_stb_i & ~is_mapped(wb_adr_i);

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			wb_dat_o <= 8'h00;
		end else if (hit) begin
			unique case (wb_adr_i)
				OFS_CSR: wb_dat_o <= {1'b0, trim_q, 2'b00, bor_q, warn_live, ie_q};
				OFS_THR: wb_dat_o <= {1'b0, presc_q, 3'b000, thr_q};
				default: wb_dat_o <= 8'h00;
			endcase
		end
	end

	// reserved bits are not stored, so stray ones read back zero
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			thr_q <= `SIMON_THR_RESET;
			presc_q <= 2'h0;
		end else if (wr && wb_adr_i == OFS_THR) begin
			thr_q <= wb_dat_i[1:0];
			presc_q <= wb_dat_i[6:5];
		end
	end
	assign o_warning_threshold_field = thr_q;
	assign o_osc_prescaler_select = presc_q;

	property p_thr_reset;
		@(posedge i_clk_sys) i_reset |=> thr_q == `SIMON_THR_RESET;
	endproperty
	a_thr_reset: assert property (p_thr_reset)
		else $error("threshold not 11 after reset");

	property p_warn_off;
		@(posedge i_clk_sys) disable iff (i_reset)
			wb_ack_o && !wb_we_i && wb_adr_i == OFS_CSR && thr_q == `SIMON_THR_OFF
			|-> !wb_dat_o[`SIMON_BIT_WARN];
	endproperty
	a_warn_off: assert property (p_warn_off)
		else $error("warning read while switched off");

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			trim_q <= `SIMON_TRIM_RESET;
			ie_q <= 1'b0;
		end else if (wr && wb_adr_i == OFS_CSR) begin
			trim_q <= wb_dat_i[6:5];
			ie_q <= wb_dat_i[`SIMON_BIT_IE];
		end
	end
	assign o_osc_trim_low_bits = trim_q;

	property p_trim_reset;
		@(posedge i_clk_sys) i_reset |=> trim_q == `SIMON_TRIM_RESET;
	endproperty
	a_trim_reset: assert property (p_trim_reset)
		else $error("trim not 11 after reset");

	property p_halt;
		@(posedge i_clk_sys) disable iff (i_reset)
			frozen |=> $stable(ie_q) && $stable(thr_q) && $stable(trim_q);
	endproperty
	a_halt: assert property (p_halt)
		else $error("halt not frozen");

	// warning edge tracking, both directions raise the event
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			warn_prev_q <= 1'b0;
		end else begin
			warn_prev_q <= warn_live;
		end
	end
	assign warn_edge = warn_live ^ warn_prev_q;

	// pending latch; new event wins over service clear
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			pend_q <= 1'b0;
		end else if (warn_edge && !frozen) begin
			pend_q <= 1'b1;
		end else if (i_irq_ack) begin
			pend_q <= 1'b0;
		end
	end
	assign o_warning_irq = pend_q & ie_q & ~i_cpu_imask;
	assign o_wake_wait = (i_mode == SIMON_WAIT) & pend_q & ie_q;

	property p_irq_gate;
		@(posedge i_clk_sys) disable iff (i_reset) o_warning_irq |-> ie_q && !i_cpu_imask;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("irq without enable");

	property p_edge_pend;
		@(posedge i_clk_sys) disable iff (i_reset) warn_edge && !frozen |=> pend_q;
	endproperty
	a_edge_pend: assert property (p_edge_pend)
		else $error("edge not pended");

	property p_ack_clr;
		@(posedge i_clk_sys) disable iff (i_reset) i_irq_ack && !warn_edge |=> !pend_q;
	endproperty
	a_ack_clr: assert property (p_ack_clr)
		else $error("ack not cleared");

	property p_pend_hold;
		@(posedge i_clk_sys) disable iff (i_reset) pend_q && !i_irq_ack |=> pend_q;
	endproperty
	a_pend_hold: assert property (p_pend_hold)
		else $error("pending lost without service");

	property p_wait;
		@(posedge i_clk_sys) disable iff (i_reset) frozen |-> !o_wake_wait;
	endproperty
	a_wait: assert property (p_wait)
		else $error("halt wake");

	property p_wake_mode;
		@(posedge i_clk_sys) disable iff (i_reset)
			pend_q && ie_q && i_mode == SIMON_WAIT |-> o_wake_wait;
	endproperty
	a_wake_mode: assert property (p_wake_mode)
		else $error("no wake from wait");

	// dip length counter; short dips on internal clock do not flag
	always_ff @(posedge i_clk_sys) begin
		if (i_reset && !bo_s) begin
			dip_q <= 16'h0000;
		end else if (bo_s) begin
			if (dip_q != 16'hFFFF) begin
				dip_q <= dip_q + 16'h0001;
			end
		end else begin
			dip_q <= 16'h0000;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_por_n) begin
			bo_prev_q <= 1'b0;
			halt_seen_q <= 1'b0;
		end else begin
			bo_prev_q <= bo_s;
			if (!bo_s) begin
				halt_seen_q <= frozen;
			end
		end
	end

	always_comb begin
		bo_capture = bo_prev_q & ~bo_s & i_opt_brownout_enable;
		if (i_internal_clk && dip_q < 16'(WAKE_CYC)) begin
			bo_capture = 1'b0;
		end
		if (i_clk_external && (halt_seen_q || !i_ext_clk_fast)) begin
			bo_capture = 1'b0;
		end
	end

	// flag cleared by power-on or by a CSR read outside halt; other resets leave it
	always_ff @(posedge i_clk_sys) begin
		if (!i_por_n) begin
			bor_q <= 1'b0;
		end else if (bo_capture) begin
			bor_q <= 1'b1;
		end else if (rd && wb_adr_i == OFS_CSR && !frozen) begin
			bor_q <= 1'b0;
		end
	end

	assign o_watchdog_reset_flag_clr = bo_capture;

	property p_bor_keep;
		@(posedge i_clk_sys) disable iff (!i_por_n) bor_q && !rd |=> bor_q;
	endproperty
	a_bor_keep: assert property (p_bor_keep)
		else $error("brownout flag lost");

	property p_bor_set;
		@(posedge i_clk_sys) disable iff (!i_por_n) bo_capture |=> bor_q;
	endproperty
	a_bor_set: assert property (p_bor_set)
		else $error("brownout flag not set");

	property p_bor_clr;
		@(posedge i_clk_sys) disable iff (!i_por_n)
			rd && wb_adr_i == OFS_CSR && !frozen && !bo_capture |=> !bor_q;
	endproperty
	a_bor_clr: assert property (p_bor_clr)
		else $error("brownout flag not cleared by read");
endmodule

// ### test_simon_top.sv
// self-checking bench for the supply integrity monitor
`timescale 1ns/1ps
`include "simon_defs.svh"
module test_simon_top;
	import simon_pkg::*;
	logic i_clk_sys = 1'b0;
	logic i_reset = 1'b1;
	logic i_por_n = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [7:0] wb_dat_i = 8'h00;
	logic wb_we_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic warn_below = 1'b0;
	logic bo_below = 1'b0;
	logic service_en = 1'b0;
	logic i_cpu_imask = 1'b1;
	logic i_wdg_reset = 1'b0;
	logic i_illegal_op = 1'b0;
	logic i_ext_clk_fast = 1'b0;
	logic i_internal_clk = 1'b1;
	logic clk_ext = 1'b0;
	logic wdg_clr_seen = 1'b0;
	simon_mode_t i_mode = SIMON_RUN;
	logic [7:0] wb_dat_o, rdat;
	logic wb_ack_o, wb_err_o, err, warn_cmp, bo_cmp, irq_ack, irq, wake, chip_rst, pin_oe, wclr;
	logic [1:0] thr_o, trim_o, presc_o, lvl_o;
	logic bod_on, pin_out;
	int mismatches = 0;
	int samples_checked = 0;
	always #12.5 i_clk_sys = ~i_clk_sys;
	simon_supply_model model_u (.i_clk_sys(i_clk_sys), .i_warn_below(warn_below),
		.i_bo_below(bo_below), .i_service_en(service_en), .i_warning_irq(irq),
		.o_warn_cmp(warn_cmp), .o_brownout_cmp(bo_cmp), .o_irq_ack(irq_ack));
	simon_top dut_u (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_por_n(i_por_n),
		.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
		.wb_sel_i(1'b1), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
		.wb_err_o(wb_err_o), .i_warn_cmp(warn_cmp), .i_brownout_cmp(bo_cmp),
		.i_reset_pin_n(~pin_oe), .i_opt_brownout_level(2'h1), .i_opt_brownout_enable(1'b1),
		.i_clk_external(clk_ext), .i_ext_clk_fast(i_ext_clk_fast), .i_internal_clk(i_internal_clk),
		.i_wdg_reset(i_wdg_reset), .i_illegal_op(i_illegal_op), .i_cpu_imask(i_cpu_imask),
		.i_irq_ack(irq_ack), .i_mode(i_mode), .o_warning_irq(irq), .o_wake_wait(wake),
		.o_chip_reset(chip_rst), .o_reset_pin_out(pin_out), .o_reset_pin_oe(pin_oe),
		.o_warning_threshold_field(thr_o), .o_osc_trim_low_bits(trim_o),
		.o_osc_prescaler_select(presc_o), .o_brownout_level(lvl_o),
		.o_brownout_detector_on(bod_on), .o_watchdog_reset_flag_clr(wclr));
	always @(posedge i_clk_sys) begin
		if (wclr === 1'b1) wdg_clr_seen <= 1'b1;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic xfer(input logic [7:0] adr, input logic we, input logic [7:0] wdat);
		int n;
		n = 0;
		@(posedge i_clk_sys);
		wb_adr_i <= adr;
		wb_we_i <= we;
		wb_dat_i <= wdat;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			$display("MISMATCH bus answer expected 1 seen 0");
		end
		rdat = wb_dat_o;
		err = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] adr, input logic [7:0] exp, input string what);
		xfer(adr, 1'b0, 8'h00);
		check(what, exp, rdat);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask
	task automatic dip(input int n);
		bo_below <= 1'b1;
		cyc(n);
		bo_below <= 1'b0;
		cyc(12);
	endtask
	initial begin
		cyc(8);
		i_reset <= 1'b0;
		i_por_n <= 1'b1;
		rd(`SIMON_OFS_CSR, 8'h60, "csr reset");
		rd(`SIMON_OFS_THR, 8'h03, "thr reset");
		check("option pins", 8'h05, {5'h00, bod_on, lvl_o});
		xfer(8'h10, 1'b0, 8'h00);
		check("unmapped err", 8'h01, {7'h00, err});
		for (int i = 0; i < 3; i++) begin
			xfer(`SIMON_OFS_THR, 1'b1, 8'(i));
			rd(`SIMON_OFS_THR, 8'(i), "thr field");
		end
		xfer(`SIMON_OFS_THR, 1'b1, 8'h62);
		rd(`SIMON_OFS_THR, 8'h62, "thr prescaler");
		check("field pins", 8'h3E, {2'h0, trim_o, presc_o, thr_o});
		xfer(`SIMON_OFS_CSR, 1'b1, 8'h61);
		warn_below <= 1'b1;
		cyc(12);
		check("irq masked", 8'h00, {7'h00, irq});
		i_cpu_imask <= 1'b0;
		i_mode <= SIMON_WAIT;
		cyc(2);
		check("irq falling", 8'h01, {7'h00, irq});
		check("wait wake", 8'h01, {7'h00, wake});
		service_en <= 1'b1;
		cyc(10);
		check("irq serviced", 8'h00, {7'h00, irq});
		i_mode <= SIMON_RUN;
		rd(`SIMON_OFS_CSR, 8'h63, "csr warning");
		service_en <= 1'b0;
		warn_below <= 1'b0;
		cyc(12);
		check("irq rising", 8'h01, {7'h00, irq});
		service_en <= 1'b1;
		i_mode <= SIMON_HALT;
		xfer(`SIMON_OFS_THR, 1'b1, 8'h01);
		i_mode <= SIMON_RUN;
		rd(`SIMON_OFS_THR, 8'h62, "thr frozen");
		i_illegal_op <= 1'b1;
		cyc(3);
		check("illegal reset", 8'h01, {7'h00, chip_rst});
		i_illegal_op <= 1'b0;
		i_wdg_reset <= 1'b1;
		bo_below <= 1'b1;
		cyc(12);
		check("brownout pin", 8'h03, {5'h00, pin_out, chip_rst, pin_oe});
		cyc(1400);
		bo_below <= 1'b0;
		i_wdg_reset <= 1'b0;
		cyc(12);
		check("wdg flag clr", 8'h01, {7'h00, wdg_clr_seen});
		i_reset <= 1'b1;
		cyc(2);
		i_reset <= 1'b0;
		rd(`SIMON_OFS_THR, 8'h03, "thr after reset");
		rd(`SIMON_OFS_CSR, 8'h64, "flag kept");
		rd(`SIMON_OFS_CSR, 8'h60, "flag read clr");
		dip(100);
		rd(`SIMON_OFS_CSR, 8'h60, "short dip");
		i_internal_clk <= 1'b0;
		clk_ext <= 1'b1;
		dip(20);
		rd(`SIMON_OFS_CSR, 8'h60, "slow ext clk");
		i_ext_clk_fast <= 1'b1;
		dip(20);
		rd(`SIMON_OFS_CSR, 8'h64, "fast ext clk");
		i_mode <= SIMON_HALT;
		dip(20);
		i_mode <= SIMON_RUN;
		rd(`SIMON_OFS_CSR, 8'h60, "halt ext clk");
		conclude();
	end
	initial begin
		cyc(20000);
		mismatches++;
		conclude();
	end
endmodule
